/* File: rtl/uart_rx_err_irq.sv */
// uart receiver with error flags, interrupt gating, address detect and line wake-up
// assumes aclk is the system clock, rx_line is asynchronous, tx flags come from the same clock
//
// Behaviour
// - two buffered words, third sets overrun
// - overrun keeps buffer, drops word, interrupts
// - overrun clears on status then data
// - noise flag rises with data-available, no interrupt
// - noise clears on status then data read; here a data read alone pops the word and its noise flag
// - low stop bit sets framing error
// - framing error stored with word, reset clears
// - parity error when enabled and wrong
// - interrupt is a low pulse, five sources
// - tx enables separate, rx enable shared
// - flags read-only, cleared by access sequence; here only overrun needs it, noise, framing and parity clear on any data read
// - address detect needs high top bit
// - without address detect, every word interrupts
// - falling line edge wakes when clock stopped
// - receive data ignored during start-up period
// - wake interrupt gated, issued after start-up
// - stopped clock pauses the reception
// - sleep leaves registers unchanged
// - data-available clears on status then data; here a data read of the last word clears it, status read or not
// - break is framing error with zeros
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
module uart_rx_err_irq #(
	parameter int unsigned STARTUP_LEN = uart_rx_pkg::STARTUP_CYCLES,
	parameter int unsigned FIFO_DEPTH = 2
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial line and power
	input wire logic rx_line,
	input wire logic uart_clk_stop,
	input wire logic tx_empty,
	input wire logic tx_idle,
	// to the system
	output logic uart_irq_n,
	output logic wake_req
);
	import uart_rx_pkg::*;

	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam logic [PW:0] DEPTH_CNT = (PW+1)'(FIFO_DEPTH);

	function automatic logic majority(input logic [2:0] s);
		majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// registers
	logic [12:0] ctrl_q;
	logic [15:0] baud_q;
	ctrl_t ctrl;
	assign ctrl = ctrl_t'(ctrl_q);

	// bus decode
	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
	wire wr_ctrl = wr_go & (s_axi_awaddr == CONTROL_OFS);
	wire wr_baud = wr_go & (s_axi_awaddr == BAUD_OFS);
	wire wr_mapped = (s_axi_awaddr == STATUS_OFS) | (s_axi_awaddr == CONTROL_OFS) |
		(s_axi_awaddr == DATA_OFS) | (s_axi_awaddr == BAUD_OFS);
	wire rd_status = rd_go & (s_axi_araddr == STATUS_OFS);
	wire rd_data = rd_go & (s_axi_araddr == DATA_OFS);
	wire status_access = rd_status | (wr_go & (s_axi_awaddr == STATUS_OFS));
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;

	// line synchroniser, level changes once stages two and three agree
	logic [2:0] rx_sync_q;
	logic rx_lvl_q;
	wire rx_lvl_d = (rx_sync_q[1] == rx_sync_q[2]) ? rx_sync_q[2] : rx_lvl_q;
	wire rx_fall = rx_lvl_q & ~rx_lvl_d;

	// receiver state
	rx_state_t rx_state_q;
	logic [15:0] baud_cnt_q;
	logic [3:0] sub_q;
	logic [3:0] bit_cnt_q;
	logic [2:0] samp_q;
	logic [8:0] shift_q;
	logic par_acc_q, nf_q, framing_error_flag_q, parity_error_flag_q;
	logic [31:0] ignore_q;

	wire ignoring = (ignore_q != 32'h0);
	wire run = ~uart_clk_stop & ctrl.uart_enable & ctrl.rx_enable;
	wire tick = run & (baud_cnt_q == baud_q);
	wire bit_end = tick & (sub_q == OVERSAMPLE_LAST);
	wire bit_val = majority(samp_q);
	wire samp_noise = (samp_q != 3'b000) & (samp_q != 3'b111);
	wire [3:0] nbits = ctrl.nine_bit_select ? BITS_NINE : BITS_EIGHT;
	wire last_stop = bit_end & ((rx_state_q == RX_STOP2) | ((rx_state_q == RX_STOP1) & ~ctrl.two_stop_bits));
	wire stop_low = bit_end & ~bit_val & ((rx_state_q == RX_STOP1) | (rx_state_q == RX_STOP2));
	wire frame_framing_error_flag = framing_error_flag_q | stop_low;
	wire [8:0] frame_word = ctrl.nine_bit_select ? shift_q : {1'b0, shift_q[8:1]};
	wire is_break = frame_framing_error_flag & (frame_word == 9'h000) & ~bit_val;

	// buffer
	rx_entry_t mem_q [FIFO_DEPTH];
	logic [PW-1:0] wr_ptr_q, rd_ptr_q;
	logic [PW:0] count_q;
	wire full = (count_q == DEPTH_CNT);
	wire empty = (count_q == '0);
	wire push_ok = last_stop & ~full;
	wire ovr_evt = last_stop & full;
	wire pop = rd_data & ~empty;
	rx_entry_t head;
	assign head = mem_q[rd_ptr_q];
	rx_entry_t new_entry;
	assign new_entry = '{word: is_break ? 9'h000 : frame_word, framing_error: frame_framing_error_flag,
		parity_error: parity_error_flag_q, noise: nf_q | (bit_end & samp_noise)};
	wire push_msb = ctrl.nine_bit_select ? frame_word[8] : frame_word[7];

	// access sequence arming and overrun flag
	logic armed_q, ovr_q;

	// status word
	wire [7:0] status_word = {tx_empty, tx_idle, ~empty, rx_state_q == RX_IDLE, ovr_q,
		~empty & head.noise, ~empty & head.framing_error, ~empty & head.parity_error};

	// interrupt sources
	logic tx_empty_q, tx_idle_q;
	logic [31:0] wake_wait_q;
	logic wake_pend_q;
	wire wake_cond = uart_clk_stop & ctrl.wake_enable & ctrl.uart_enable & ctrl.rx_enable &
		ctrl.rx_int_enable;
	wire wake_evt = wake_cond & rx_fall;
	wire wake_done = wake_pend_q & (wake_wait_q == 32'h1);
	wire int_gate = ctrl.global_int_enable & ctrl.uart_int_enable;
	wire rx_src = ctrl.rx_int_enable & ((push_ok & (~ctrl.addr_detect_enable | push_msb)) | ovr_evt);
	wire tx_src = (ctrl.tx_empty_int_enable & tx_empty & ~tx_empty_q) |
		(ctrl.tx_idle_int_enable & tx_idle & ~tx_idle_q);
	wire wake_src = wake_done;
	wire irq_fire = int_gate & (rx_src | tx_src | wake_src);

	// registers keep their values while the clock source is stopped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CONTROL_RST;
			baud_q <= BAUD_RST;
		end else begin
			if (wr_ctrl)
				ctrl_q <= s_axi_wdata[12:0];
			if (wr_baud)
				baud_q <= s_axi_wdata[15:0];
		end
	end

	// bus responses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h0;
		end else begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				if (s_axi_araddr == STATUS_OFS)
					s_axi_rdata <= {24'h0, status_word};
				else if (s_axi_araddr == CONTROL_OFS)
					s_axi_rdata <= {19'h0, ctrl_q};
				else if (s_axi_araddr == DATA_OFS)
					s_axi_rdata <= {23'h0, empty ? 9'h000 : head.word};
				else if (s_axi_araddr == BAUD_OFS)
					s_axi_rdata <= {16'h0, baud_q};
				else begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// line sampling
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_sync_q <= 3'b111;
			rx_lvl_q <= 1'b1;
		end else begin
			rx_sync_q <= {rx_sync_q[1:0], rx_line};
			rx_lvl_q <= rx_lvl_d;
		end
	end

	// oversampling timer
	always_ff @(posedge aclk) begin
		if (!aresetn || rx_state_q == RX_IDLE) begin
			baud_cnt_q <= 16'h0;
			sub_q <= 4'h0;
			samp_q <= 3'b000;
		end else if (run) begin
			baud_cnt_q <= tick ? 16'h0 : baud_cnt_q + 1'b1;
			if (tick) begin
				sub_q <= sub_q + 1'b1;
				if (sub_q >= SAMPLE_A && sub_q <= SAMPLE_C)
					samp_q <= {samp_q[1:0], rx_lvl_q};
			end
		end
	end

	// frame state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_state_q <= RX_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q <= 9'h000;
			par_acc_q <= 1'b0;
			nf_q <= 1'b0;
			framing_error_flag_q <= 1'b0;
			parity_error_flag_q <= 1'b0;
		end else begin
			if (bit_end && samp_noise)
				nf_q <= 1'b1;
			case (rx_state_q)
				RX_IDLE: begin
					nf_q <= 1'b0;
					framing_error_flag_q <= 1'b0;
					parity_error_flag_q <= 1'b0;
					par_acc_q <= 1'b0;
					bit_cnt_q <= 4'h0;
					if (run && rx_fall && !ignoring)
						rx_state_q <= RX_START;
				end
				RX_START: begin
					if (bit_end)
						rx_state_q <= bit_val ? RX_IDLE : RX_DATA;
				end
				RX_DATA: begin
					if (bit_end) begin
						shift_q <= {bit_val, shift_q[8:1]};
						par_acc_q <= par_acc_q ^ bit_val;
						bit_cnt_q <= bit_cnt_q + 1'b1;
						if (bit_cnt_q == nbits - 1'b1)
							rx_state_q <= ctrl.parity_enable ? RX_PARITY : RX_STOP1;
					end
				end
				RX_PARITY: begin
					if (bit_end) begin
						parity_error_flag_q <= (par_acc_q ^ bit_val) ^ ctrl.parity_odd;
						rx_state_q <= RX_STOP1;
					end
				end
				RX_STOP1: begin
					if (bit_end) begin
						framing_error_flag_q <= frame_framing_error_flag;
						if (ctrl.two_stop_bits)
							rx_state_q <= RX_STOP2;
						else
							rx_state_q <= is_break ? RX_BREAK : RX_IDLE;
					end
				end
				RX_STOP2: begin
					if (bit_end)
						rx_state_q <= is_break ? RX_BREAK : RX_IDLE;
				end
				RX_BREAK: begin
					if (run && rx_lvl_q)
						rx_state_q <= RX_IDLE;
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// two-word receive buffer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			for (int i = 0; i < FIFO_DEPTH; i++)
				mem_q[i] <= '0;
		end else begin
			if (push_ok) begin
				mem_q[wr_ptr_q] <= new_entry;
				wr_ptr_q <= ptr_inc(wr_ptr_q);
			end
			if (pop)
				rd_ptr_q <= ptr_inc(rd_ptr_q);
			count_q <= count_q + (PW+1)'(push_ok) - (PW+1)'(pop);
		end
	end

	// overrun flag, a new overrun wins over the clearing read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			if (status_access)
				armed_q <= 1'b1;
			else if (rd_data)
				armed_q <= 1'b0;
			if (ovr_evt)
				ovr_q <= 1'b1;
			else if (rd_data && armed_q)
				ovr_q <= 1'b0;
		end
	end

	// wake-up, start-up wait and interrupt pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_empty_q <= 1'b0;
			tx_idle_q <= 1'b0;
			wake_req <= 1'b0;
			wake_pend_q <= 1'b0;
			wake_wait_q <= 32'h0;
			ignore_q <= 32'h0;
			uart_irq_n <= 1'b1;
		end else begin
			tx_empty_q <= tx_empty;
			tx_idle_q <= tx_idle;
			wake_req <= wake_evt;
			if (wake_evt) begin
				wake_pend_q <= 1'b1;
				wake_wait_q <= STARTUP_LEN;
				ignore_q <= STARTUP_LEN;
			end else begin
				if (wake_wait_q != 32'h0)
					wake_wait_q <= wake_wait_q - 1'b1;
				if (wake_done)
					wake_pend_q <= 1'b0;
				if (ignoring)
					ignore_q <= ignore_q - 1'b1;
			end
			uart_irq_n <= ~irq_fire;
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	irq_low_pulse_a: assert property (!uart_irq_n |=> uart_irq_n)
		else $error("interrupt low for more than one cycle");
	ovr_set_a: assert property (last_stop && full |=> ovr_q && count_q == DEPTH_CNT - (PW+1)'($past(pop)))
		else $error("overrun not flagged when buffer full");
	ovr_keep_a: assert property (ovr_evt && !pop |=> $stable(rd_ptr_q) && $stable(wr_ptr_q))
		else $error("buffer changed on overrun");
	ovr_clear_a: assert property (status_access ##1 (rd_data && !ovr_evt && !status_access) |=> !ovr_q)
		else $error("overrun not cleared by access sequence");
	ovr_hold_a: assert property (ovr_q && !(rd_data && armed_q) |=> ovr_q)
		else $error("overrun cleared without sequence");
	addr_gate_a: assert property (push_ok && ctrl.addr_detect_enable && !push_msb && !ovr_evt
		&& !tx_src && !wake_src |=> uart_irq_n)
		else $error("address detect let data word interrupt");
	no_addr_a: assert property (push_ok && !ctrl.addr_detect_enable && ctrl.rx_int_enable && int_gate
		|=> !uart_irq_n)
		else $error("received word raised no interrupt");
	stop_framing_error_flag_a: assert property (rx_state_q == RX_STOP1 && bit_end && !bit_val && !ctrl.two_stop_bits && !full
		|=> mem_q[$past(wr_ptr_q)].framing_error)
		else $error("low stop bit not flagged");
	pause_a: assert property (uart_clk_stop && rx_state_q != RX_IDLE |=> $stable(sub_q) && $stable(baud_cnt_q))
		else $error("reception advanced with clock stopped");
	wake_evt_a: assert property (wake_cond && rx_fall |=> wake_req ##1 (ignore_q != 32'h0))
		else $error("falling edge did not wake");
	wake_late_a: assert property (wake_evt |=> uart_irq_n || rx_src || tx_src)
		else $error("wake interrupt before start-up elapsed");
	sleep_hold_a: assert property (uart_clk_stop && !wr_ctrl && !wr_baud |=> $stable(ctrl_q) && $stable(baud_q))
		else $error("control changed while clock stopped");
endmodule // uart_rx_err_irq

/* File: rtl/uart_rx_pkg.sv */
// constants, register map and carrier types of the uart receive-side error, interrupt and wake block
// assumes a single 20 MHz system clock and a 32-bit axi4-lite register bus
package uart_rx_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned STARTUP_NS = 51200;
	localparam int unsigned STARTUP_CYCLES = (STARTUP_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
	localparam logic [3:0] SAMPLE_A = 4'h7;
	localparam logic [3:0] SAMPLE_C = 4'h9;
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;

	// register byte offsets
	localparam logic [3:0] STATUS_OFS = 4'h0;
	localparam logic [3:0] CONTROL_OFS = 4'h4;
	localparam logic [3:0] DATA_OFS = 4'h8;
	localparam logic [3:0] BAUD_OFS = 4'hc;

	// reset values
	localparam logic [12:0] CONTROL_RST = 13'h0000;
	localparam logic [15:0] BAUD_RST = 16'h0000;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// control register layout, bit 12 down to bit 0
	typedef struct packed {
		logic global_int_enable;
		logic uart_int_enable;
		logic tx_empty_int_enable;
		logic tx_idle_int_enable;
		logic rx_int_enable;
		logic wake_enable;
		logic addr_detect_enable;
		logic two_stop_bits;
		logic parity_odd;
		logic parity_enable;
		logic nine_bit_select;
		logic rx_enable;
		logic uart_enable;
	} ctrl_t;

	// one buffered received word with its own error flags
	typedef struct packed {
		logic [8:0] word;
		logic framing_error;
		logic parity_error;
		logic noise;
	} rx_entry_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP1 = 3'b100,
		RX_STOP2 = 3'b101,
		RX_BREAK = 3'b110
	} rx_state_t;
endpackage

/* File: dv/uart_line_tx.sv */
// serial transmitter model on the receive line of the uart block
// assumes the bench calls its tasks from one process; one bit lasts BIT_CYC clocks
module uart_line_tx #(
	parameter int BIT_CYC = 32
) (
	// clock
	input wire logic aclk,
	// line, idle high
	output logic rx_line
);
	initial rx_line = 1'b1;
	// g flips two clocks at mid bit, hitting one of the three samples
	task automatic bit_out(input logic b, input logic g);
		for (int c = 0; c < BIT_CYC; c++) begin
			@(posedge aclk);
			rx_line <= (g && c >= BIT_CYC / 2 && c < BIT_CYC / 2 + 2) ? ~b : b;
		end
	endtask
	// frame lsb first, stop levels set by caller, then one idle bit time
	task automatic send(input logic [8:0] w, input int nb, input logic pon, input logic pb,
			input logic [1:0] stp, input int ns, input int gb);
		bit_out(1'b0, 1'b0);
		for (int i = 0; i < nb; i++)
			bit_out(w[i], i == gb);
		if (pon)
			bit_out(pb, 1'b0);
		for (int i = 0; i < ns; i++)
			bit_out(stp[i], 1'b0);
		@(posedge aclk);
		rx_line <= 1'b1;
		repeat (BIT_CYC) @(posedge aclk);
	endtask
	// bare falling edge, as seen while the uart clock is stopped
	task automatic low_pulse(input int len);
		@(posedge aclk);
		rx_line <= 1'b0;
		repeat (len) @(posedge aclk);
		rx_line <= 1'b1;
	endtask
endmodule // uart_line_tx

/* File: dv/uart_rx_err_irq_tb.sv */
// self-checking bench of the uart receive error, interrupt and wake block
// assumes uart_line_tx on the line, a 50 ns clock and baud divider 1 (32 clocks a bit)
module uart_rx_error_irq_wake_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import uart_rx_pkg::*;
	localparam int SL = 512;
	localparam logic [31:0] RXON = 32'h1903;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic clk_stop = 1'b0, tx_empty = 1'b0, tx_idle = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq_n, wake_req, rx_line;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata, d;
	int errors = 0, cmp_count = 0, irqs = 0, wakes = 0;
	`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
		$display("ERROR %0t got %h expected %h", $time, (a), (b)); end end

	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		if (irq_n === 1'b0)
			irqs++;
		if (wake_req === 1'b1)
			wakes++;
	end

	uart_rx_err_irq #(.STARTUP_LEN(SL), .FIFO_DEPTH(2)) uart_rx_err_irq_inst (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rx_line(rx_line), .uart_clk_stop(clk_stop), .tx_empty(tx_empty), .tx_idle(tx_idle),
		.uart_irq_n(irq_n), .wake_req(wake_req)
	);
	uart_line_tx #(.BIT_CYC(32)) uart_line_tx_inst (.aclk(aclk), .rx_line(rx_line));

	task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid !== 1'b1) @(posedge aclk);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
		rd(a, d, r);
		`CHK(d, e)
	endtask
	task automatic snd(input logic [8:0] w, input int nb);
		uart_line_tx_inst.send(w, nb, 1'b0, 1'b0, 2'b11, 1, -1);
	endtask

	task automatic t_regs;
		chk_rd(CONTROL_OFS, 32'h0);
		chk_rd(BAUD_OFS, 32'h0);
		chk_rd(STATUS_OFS, 32'h10);
		wr(STATUS_OFS, 32'hff, r);
		`CHK(r, RESP_OKAY)
		chk_rd(STATUS_OFS, 32'h10);
		wr(4'h6, 32'h1, r);
		`CHK(r, RESP_SLVERR)
		rd(4'h6, d, r);
		`CHK(r, RESP_SLVERR)
		`CHK(d, 32'h0)
		wr(BAUD_OFS, 32'h1, r);
		chk_rd(BAUD_OFS, 32'h1);
	endtask
	task automatic t_overrun;
		int n;
		wr(CONTROL_OFS, RXON, r);
		n = irqs;
		snd(9'h011, 8);
		snd(9'h022, 8);
		snd(9'h033, 8);
		`CHK(irqs - n, 3)
		chk_rd(STATUS_OFS, 32'h38);
		chk_rd(DATA_OFS, 32'h11);
		chk_rd(STATUS_OFS, 32'h30);
		chk_rd(DATA_OFS, 32'h22);
		chk_rd(STATUS_OFS, 32'h10);
		chk_rd(DATA_OFS, 32'h0);
	endtask
	task automatic t_errors;
		int n;
		uart_line_tx_inst.send(9'h0a5, 8, 1'b0, 1'b0, 2'b00, 1, -1);
		chk_rd(STATUS_OFS, 32'h32);
		chk_rd(DATA_OFS, 32'ha5);
		wr(CONTROL_OFS, RXON | 32'h20, r);
		uart_line_tx_inst.send(9'h05a, 8, 1'b0, 1'b0, 2'b01, 2, -1);
		chk_rd(STATUS_OFS, 32'h32);
		chk_rd(DATA_OFS, 32'h5a);
		wr(CONTROL_OFS, RXON | 32'h08, r);
		uart_line_tx_inst.send(9'h013, 8, 1'b1, 1'b0, 2'b11, 1, -1);
		chk_rd(STATUS_OFS, 32'h31);
		chk_rd(DATA_OFS, 32'h13);
		wr(CONTROL_OFS, RXON | 32'h18, r);
		uart_line_tx_inst.send(9'h013, 8, 1'b1, 1'b0, 2'b11, 1, -1);
		chk_rd(STATUS_OFS, 32'h30);
		chk_rd(DATA_OFS, 32'h13);
		wr(CONTROL_OFS, RXON, r);
		uart_line_tx_inst.send(9'h000, 8, 1'b0, 1'b0, 2'b00, 1, -1);
		chk_rd(STATUS_OFS, 32'h32);
		chk_rd(DATA_OFS, 32'h0);
		n = irqs;
		uart_line_tx_inst.send(9'h0c3, 8, 1'b0, 1'b0, 2'b11, 1, 3);
		`CHK(irqs - n, 1)
		chk_rd(STATUS_OFS, 32'h34);
		chk_rd(DATA_OFS, 32'hc3);
		chk_rd(STATUS_OFS, 32'h10);
	endtask
	task automatic t_addr;
		int n;
		wr(CONTROL_OFS, RXON | 32'h40, r);
		n = irqs;
		snd(9'h07f, 8);
		`CHK(irqs - n, 0)
		snd(9'h080, 8);
		`CHK(irqs - n, 1)
		chk_rd(DATA_OFS, 32'h7f);
		chk_rd(DATA_OFS, 32'h80);
		wr(CONTROL_OFS, RXON | 32'h44, r);
		snd(9'h0ff, 9);
		snd(9'h100, 9);
		`CHK(irqs - n, 2)
		chk_rd(DATA_OFS, 32'hff);
		chk_rd(DATA_OFS, 32'h100);
	endtask
	task automatic t_tx;
		int n;
		wr(CONTROL_OFS, RXON | 32'h400, r);
		n = irqs;
		tx_empty <= 1'b1;
		tx_idle <= 1'b1;
		repeat (4) @(posedge aclk);
		`CHK(irqs - n, 1)
		chk_rd(STATUS_OFS, 32'hd0);
		tx_empty <= 1'b0;
		tx_idle <= 1'b0;
		wr(CONTROL_OFS, RXON | 32'h200, r);
		n = irqs;
		tx_idle <= 1'b1;
		repeat (4) @(posedge aclk);
		`CHK(irqs - n, 1)
		chk_rd(STATUS_OFS, 32'h50);
		tx_idle <= 1'b0;
	endtask
	task automatic t_wake(input logic [31:0] c, input int ni);
		int n, w;
		wr(CONTROL_OFS, c, r);
		clk_stop <= 1'b1;
		n = irqs;
		w = wakes;
		uart_line_tx_inst.low_pulse(8);
		repeat (6) @(posedge aclk);
		`CHK(wakes - w, 1)
		chk_rd(CONTROL_OFS, c);
		clk_stop <= 1'b0;
		snd(9'h055, 8);
		`CHK(irqs - n, 0)
		chk_rd(STATUS_OFS, 32'h10);
		repeat (150) @(posedge aclk);
		`CHK(irqs - n, ni)
	endtask

	task automatic complete_run;
		if (errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_overrun();
		t_errors();
		t_addr();
		t_tx();
		t_wake(RXON | 32'h80, 1);
		t_wake(32'h0983, 0);
		complete_run();
	end
	initial begin
		repeat (40000) @(posedge aclk);
		errors++;
		complete_run();
	end
endmodule // uart_rx_error_irq_wake_tb
